// >>> core/bfmc_core.sv
// burst and frequency-shift keying modulation control
//
// Behaviour
// - invalid burst carrier becomes minimum frequency and reports error -221.
// - counted burst sync low during burst, high after count until next burst.
// - gated burst sync follows waveform polarity about the offset level.
// - burst count 1 to 50000 or infinite, default one cycle.
// - count not allowed at carrier frequency is set to largest allowed count.
// - internal timer expiry emits one burst, period from burst repeat rate.
// - external or backplane rising edge starts one counted burst, rate ignored.
// - gated mode ignores rate and start phase, and ignores count except in the carrier conflict check.
// - burst repeat rate 10 mHz to 50 kHz, default 100 Hz.
// - too fast a rate stretches the interval, requested rate still reported.
// - start phase -360 to +360 degrees in millidegrees, default zero.
// - arbitrary waveforms take zero phase as first loaded sample.
// - one modulation mode at a time; enabling one disables the other.
// - external hop: low input gives carrier, high gives hop frequency.
// - sync pulse longer than 200 ns on each transition to hop frequency, except on entering hop mode with the hop level already high.
// - hop toggle rate 10 mHz to 50 kHz, default 10 Hz.
// - external hop source ignores internal toggle rate.
// - hop source internal or external, default internal.
// - carrier and hop span 10 mHz to 15 MHz, 100 kHz for triangle/ramp.
// - arbitrary ceiling by sample count: 5 MHz, 2.5 MHz, 200 kHz; floor 100 mHz.
// - backplane trigger line level has inverted sense.
// - gated output runs while gate high, sits at offset while low.
`timescale 1ns/100ps
`default_nettype none
module bfmc_core
	import bfmc_pkg::*;
#(
	parameter int NUM_LINES = 8
) (
	// clock and reset
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst_n,
	// settings from the command layer
	input  wire logic               i_carrier_wr,
	input  wire logic [31:0]        i_carrier_freq,
	input  wire logic               i_hop_freq_wr,
	input  wire logic [31:0]        i_hop_frequency,
	input  wire logic               i_count_wr,
	input  wire logic               i_count_infinite,
	input  wire logic [15:0]        i_burst_cycle_count,
	input  wire logic               i_burst_rate_wr,
	input  wire logic [31:0]        i_burst_repeat_rate,
	input  wire logic               i_hop_rate_wr,
	input  wire logic [31:0]        i_hop_toggle_rate,
	input  wire logic               i_phase_wr,
	input  wire logic signed [19:0] i_burst_start_phase,
	input  wire logic [2:0]         i_wave_shape,
	input  wire logic [13:0]        i_arb_points,
	input  wire logic               i_burst_gating_select,
	input  wire logic [1:0]         i_trigger_source_select,
	input  wire logic [2:0]         i_trigger_line_index,
	input  wire logic               i_hop_source_select,
	input  wire logic               i_burst_mode_wr,
	input  wire logic               i_hop_mode_enable_wr,
	input  wire logic               i_mode_on,
	// pins
	input  wire logic               i_ext_trig,
	input  wire logic [NUM_LINES-1:0] i_backplane_trigger_line,
	// waveform engine
	input  wire logic               i_cycle_done,
	input  wire logic               i_wave_positive,
	// control outputs
	output logic                    o_sync,
	output logic                    o_wave_enable,
	output logic                    o_hop_select,
	output logic                    o_burst_active,
	output logic [1:0]              o_mode,
	// settings in force
	output logic [31:0]             o_carrier_freq,
	output logic [31:0]             o_hop_freq,
	output logic [15:0]             o_cycle_count,
	output logic                    o_count_infinite,
	output logic [31:0]             o_burst_rate,
	output logic [31:0]             o_hop_rate,
	output logic signed [19:0]      o_start_phase,
	output logic                    o_phase_from_first_sample,
	// settings conflict report
	output logic                    o_conflict,
	output logic signed [15:0]      o_error_code
);
	if (NUM_LINES < 1 || NUM_LINES > 8) begin : g_chk
		$error("NUM_LINES must be 1 to 8");
	end

	function automatic logic [15:0] min_cycles(input logic [31:0] f, input logic slow_shape);
		logic [15:0] n;
		n = CNT_MIN;
		if (!slow_shape) begin
			if (f > F_ONE_MHZ) n = 16'h0002;
			if (f > 32'(2 * F_ONE_MHZ)) n = 16'h0003;
			if (f > 32'(3 * F_ONE_MHZ)) n = 16'h0004;
			if (f > 32'(4 * F_ONE_MHZ)) n = 16'h0005;
		end
		return n;
	endfunction : min_cycles

	function automatic logic [31:0] clip(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clip

	bfmc_mode_type      mode_r;
	bfmc_bstate_type    bst_r;
	logic [NUM_LINES:0] sync1_r;
	logic [NUM_LINES:0] sync2_r;
	logic               lvl_prev_r;
	logic [31:0]        acc_r [2];
	logic [31:0]        rate_sel [2];
	logic [1:0]         tick;
	logic               pend_r;
	logic [15:0]        done_cnt_r;
	logic               hop_r;
	logic [3:0]         pulse_cnt_r;

	// frequency limits for the present shape
	wire        slow_shape = (i_wave_shape == SH_TRI) || (i_wave_shape == SH_RAMP);
	wire        is_arb     = (i_wave_shape == SH_ARB);
	wire [31:0] arb_max    = (i_arb_points <= ARB_PTS1) ? F_ARB_MAX1 :
		((i_arb_points <= ARB_PTS2) ? F_ARB_MAX2 : F_ARB_MAX3);
	wire [31:0] f_hi       = slow_shape ? F_TRI_MAX : (is_arb ? arb_max : F_STD_MAX);
	wire [31:0] f_lo       = is_arb ? F_ARB_MIN : F_MIN;
	wire [31:0] car_req    = clip(i_carrier_freq, f_lo, f_hi);
	wire        in_burst   = (mode_r == MODE_BURST);
	wire        car_bad    = in_burst && !o_count_infinite &&
		(o_cycle_count < min_cycles(car_req, slow_shape));
	wire [15:0] cnt_req    = (i_burst_cycle_count == 16'h0000) ? CNT_MIN :
		((i_burst_cycle_count > CNT_MAX) ? CNT_MAX : i_burst_cycle_count);
	wire        cnt_bad    = cnt_req < min_cycles(o_carrier_freq, slow_shape);
	wire signed [19:0] ph_req = (i_burst_start_phase > PH_MAX) ? PH_MAX :
		((i_burst_start_phase < PH_MIN) ? PH_MIN : i_burst_start_phase);

	// trigger selection, backplane lines active low
	wire [2:0] line_idx = (32'(i_trigger_line_index) < NUM_LINES) ? i_trigger_line_index : 3'h0;
	wire       sel_lvl  = (i_trigger_source_select == TS_BACKPLANE) ? ~sync2_r[line_idx] :
		sync2_r[NUM_LINES];
	wire       rise     = sel_lvl && !lvl_prev_r;
	wire       src_int  = (i_trigger_source_select == TS_INT);
	wire       counted  = in_burst && !i_burst_gating_select;
	wire       running  = (bst_r == BS_RUN);
	wire       b_start  = counted && !running && (src_int ? (tick[0] || pend_r) : rise);
	wire       cnt_last = i_cycle_done && !o_count_infinite && (done_cnt_r + 16'h0001 >= o_cycle_count);
	wire       b_stop   = running && (!counted || cnt_last);
	wire       run_nxt  = b_start || (running && !b_stop);
	wire       hop_ext  = i_hop_source_select;
	wire       hop_nxt  = hop_ext ? sel_lvl : (hop_r ^ tick[1]);
	wire       hop_rise = (mode_r == MODE_HOP) && hop_nxt && !hop_r;

	// rate generators: index 0 burst repeat, index 1 hop toggle
	assign rate_sel[0] = o_burst_rate;
	assign rate_sel[1] = o_hop_rate;
	for (genvar g = 0; g < 2; g++) begin : g_rate
		wire [32:0] sum = {1'b0, acc_r[g]} + {1'b0, rate_sel[g]};
		assign tick[g] = (sum >= {1'b0, ACC_WRAP});
		always_ff @(posedge i_clk_sys) begin
			if (!i_rst_n) begin
				acc_r[g] <= 32'h0000_0000;
			end else begin
				acc_r[g] <= tick[g] ? 32'(sum - {1'b0, ACC_WRAP}) : sum[31:0];
			end
		end
	end

	// pin synchroniser
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			// start at the idle levels so no false edge follows reset
			sync1_r <= {1'b0, {NUM_LINES{1'b1}}};
			sync2_r <= {1'b0, {NUM_LINES{1'b1}}};
		end else begin
			sync1_r <= {i_ext_trig, i_backplane_trigger_line};
			sync2_r <= sync1_r;
		end
	end

	// settings store
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_carrier_freq   <= CARRIER_DEF;
			o_hop_freq       <= HOP_DEF;
			o_cycle_count    <= CNT_MIN;
			o_count_infinite <= 1'b0;
			o_burst_rate     <= BRATE_DEF;
			o_hop_rate       <= HRATE_DEF;
			o_start_phase    <= '0;
			o_conflict       <= 1'b0;
			o_error_code     <= '0;
		end else begin
			o_conflict <= i_carrier_wr && car_bad;
			if (i_carrier_wr) begin
				o_carrier_freq <= car_bad ? f_lo : car_req;
				if (car_bad) o_error_code <= ERR_CONFLICT;
			end
			if (i_hop_freq_wr) o_hop_freq <= clip(i_hop_frequency, f_lo, f_hi);
			if (i_count_wr) begin
				o_count_infinite <= i_count_infinite;
				if (!i_count_infinite) o_cycle_count <= cnt_bad ? CNT_MAX : cnt_req;
			end
			if (i_burst_rate_wr) o_burst_rate <= clip(i_burst_repeat_rate, RATE_MIN, RATE_MAX);
			if (i_hop_rate_wr) o_hop_rate <= clip(i_hop_toggle_rate, RATE_MIN, RATE_MAX);
			if (i_phase_wr) o_start_phase <= ph_req;
		end
	end

	// mode selection and burst sequencing
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			mode_r     <= MODE_OFF;
			bst_r      <= BS_IDLE;
			pend_r     <= 1'b0;
			done_cnt_r <= '0;
			lvl_prev_r <= 1'b0;
		end else begin
			lvl_prev_r <= sel_lvl;
			if (i_hop_mode_enable_wr) begin
				mode_r <= i_mode_on ? MODE_HOP : ((mode_r == MODE_HOP) ? MODE_OFF : mode_r);
			end else if (i_burst_mode_wr) begin
				mode_r <= i_mode_on ? MODE_BURST : ((mode_r == MODE_BURST) ? MODE_OFF : mode_r);
			end
			bst_r      <= run_nxt ? BS_RUN : BS_IDLE;
			// an expiry during a burst is held so the interval stretches
			pend_r     <= counted && src_int && ((tick[0] && running) || (pend_r && !b_start));
			done_cnt_r <= (b_start || !running) ? 16'h0000 : (done_cnt_r + 16'(i_cycle_done));
		end
	end

	// hop level, sync and output steering
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			hop_r          <= 1'b0;
			pulse_cnt_r    <= '0;
			o_hop_select   <= 1'b0;
			o_sync         <= 1'b0;
			o_wave_enable  <= 1'b1;
			o_burst_active <= 1'b0;
			o_mode         <= MODE_OFF;
			o_phase_from_first_sample <= 1'b0;
		end else begin
			hop_r          <= hop_nxt;
			pulse_cnt_r    <= hop_rise ? SYNC_PULSE_CYC :
				((pulse_cnt_r != 4'h0) ? pulse_cnt_r - 4'h1 : 4'h0);
			o_hop_select   <= (mode_r == MODE_HOP) && hop_nxt;
			o_burst_active <= run_nxt;
			o_mode         <= mode_r;
			o_phase_from_first_sample <= is_arb;
			case (mode_r)
				MODE_BURST: begin
					o_wave_enable <= i_burst_gating_select ? sel_lvl : run_nxt;
					o_sync        <= i_burst_gating_select ? i_wave_positive : !run_nxt;
				end
				MODE_HOP: begin
					o_wave_enable <= 1'b1;
					o_sync        <= hop_rise || (pulse_cnt_r > 4'h1);
				end
				default: begin
					o_wave_enable <= 1'b1;
					o_sync        <= i_wave_positive;
				end
			endcase
		end
	end

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	gated_sync_a: assert property (in_burst && i_burst_gating_select |=> o_sync == $past(i_wave_positive))
		else $error("gated sync does not follow polarity");
	counted_sync_a: assert property (o_burst_active |-> !o_sync || !(o_mode == MODE_BURST))
		else $error("sync high during counted burst");
	hop_pulse_a: assert property ($rose(o_hop_select) |-> o_sync [*3] ##1 !o_sync)
		else $error("hop sync pulse length wrong");
	trig_ignore_a: assert property (running && !b_stop && rise && !src_int |=> bst_r == BS_RUN &&
		done_cnt_r == $past(done_cnt_r) + 16'($past(i_cycle_done)))
		else $error("trigger restarted a running burst");
	ext_hop_a: assert property (mode_r == MODE_HOP && hop_ext && $stable(mode_r) |=> o_hop_select == $past(sel_lvl))
		else $error("external hop level not followed");
	mode_excl_a: assert property (i_hop_mode_enable_wr && i_mode_on |=> mode_r == MODE_HOP ##1 o_mode == MODE_HOP)
		else $error("hop mode enable lost");
	conflict_a: assert property (i_carrier_wr && car_bad |=> o_conflict && o_error_code == ERR_CONFLICT && o_carrier_freq == $past(f_lo))
		else $error("carrier conflict not handled");
	count_range_a: assert property (o_cycle_count >= CNT_MIN && o_cycle_count <= CNT_MAX)
		else $error("burst count out of range");
	gate_out_a: assert property (in_burst && i_burst_gating_select && $stable(mode_r) |=> o_wave_enable == $past(sel_lvl))
		else $error("gate does not steer output");
endmodule : bfmc_core
`default_nettype wire

// >>> dv/bfmc_tb_top.sv
// self-checking bench for the burst and hop control block
`timescale 1ns/100ps
`default_nettype none
module bfmc_tb_top;
	import bfmc_pkg::*;
	logic               i_clk_sys = 1'b0;
	logic               i_rst_n = 1'b0;
	logic [7:0]         wr = 8'h00;
	logic [31:0]        fq = 32'h0000_0000;
	logic [15:0]        cnt = 16'h0000;
	logic signed [19:0] ph = 20'sh0_0000;
	logic [2:0]         shape = SH_SINE;
	logic [1:0]         tsrc = TS_EXT;
	logic [2:0]         lidx = 3'h0;
	logic               gated = 1'b0;
	logic               hop_ext = 1'b0;
	logic               mode_on = 1'b0;
	logic               inf = 1'b0;
	logic [13:0]        pts = 14'h0010;
	logic               done = 1'b0;
	logic               pos = 1'b0;
	logic               cf;
	wire logic          ext;
	wire logic [7:0]    lines;
	logic               o_sync, o_wave_enable, o_hop_select, o_burst_active, o_count_infinite;
	logic               o_phase_from_first_sample, o_conflict;
	logic [1:0]         o_mode;
	logic [31:0]        o_carrier_freq, o_hop_freq, o_burst_rate, o_hop_rate;
	logic [15:0]        o_cycle_count;
	logic signed [19:0] o_start_phase;
	logic signed [15:0] o_error_code;
	int                 error_cnt = 0;
	int                 n_tests = 0;
	int                 cyc = 0;

	always #50 i_clk_sys = ~i_clk_sys;

	bfmc_core i_bfmc_core (.i_clk_sys, .i_rst_n, .i_carrier_wr(wr[0]), .i_carrier_freq(fq),
		.i_hop_freq_wr(wr[1]), .i_hop_frequency(fq), .i_count_wr(wr[2]), .i_count_infinite(inf),
		.i_burst_cycle_count(cnt), .i_burst_rate_wr(wr[3]), .i_burst_repeat_rate(fq), .i_hop_rate_wr(wr[4]),
		.i_hop_toggle_rate(fq), .i_phase_wr(wr[5]), .i_burst_start_phase(ph), .i_wave_shape(shape),
		.i_arb_points(pts), .i_burst_gating_select(gated), .i_trigger_source_select(tsrc),
		.i_trigger_line_index(lidx), .i_hop_source_select(hop_ext), .i_burst_mode_wr(wr[6]),
		.i_hop_mode_enable_wr(wr[7]), .i_mode_on(mode_on), .i_ext_trig(ext), .i_backplane_trigger_line(lines),
		.i_cycle_done(done), .i_wave_positive(pos), .o_sync, .o_wave_enable, .o_hop_select, .o_burst_active,
		.o_mode, .o_carrier_freq, .o_hop_freq, .o_cycle_count, .o_count_infinite, .o_burst_rate, .o_hop_rate,
		.o_start_phase, .o_phase_from_first_sample, .o_conflict, .o_error_code);

	bfmc_trig_src i_bfmc_trig_src (.i_clk(i_clk_sys), .o_ext(ext), .o_lines(lines));

	task automatic close_out();
		if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// one-cycle setting strobe, conflict pulse is collected while waiting
	task automatic strb(input logic [7:0] m);
		@(posedge i_clk_sys) wr <= m;
		@(posedge i_clk_sys) wr <= 8'h00;
		#1 cf = o_conflict;
		repeat (2) @(posedge i_clk_sys) #1 cf |= o_conflict;
	endtask : strb

	task automatic wait_act(input logic v, input int lim);
		for (int k = 0; k < lim && o_burst_active !== v; k++) @(posedge i_clk_sys) #1;
		chk(o_burst_active, v);
	endtask : wait_act

	task automatic done_n(input int n);
		repeat (n) begin
			@(posedge i_clk_sys) done <= 1'b1;
			@(posedge i_clk_sys) done <= 1'b0;
		end
	endtask : done_n

	task automatic t_limits();
		@(posedge i_clk_sys) fq <= 32'h0000_0000;
		strb(8'h18);
		chk(o_burst_rate, RATE_MIN);
		chk(o_hop_rate, RATE_MIN);
		@(posedge i_clk_sys) fq <= 32'hFFFF_FFFF;
		strb(8'h18);
		chk(o_burst_rate, RATE_MAX);
		chk(o_hop_rate, RATE_MAX);
		@(posedge i_clk_sys) ph <= 20'sh7_FFFF;
		shape <= SH_ARB;
		pts <= 14'h3000;
		strb(8'h22);
		chk(o_start_phase, PH_MAX);
		chk(o_phase_from_first_sample, 1'b1);
		chk(o_hop_freq, F_ARB_MAX3);
		@(posedge i_clk_sys) ph <= 20'sh8_0000;
		shape <= SH_SINE;
		strb(8'h22);
		chk(o_hop_freq, F_STD_MAX);
		chk(o_start_phase, PH_MIN);
		chk(o_phase_from_first_sample, 1'b0);
	endtask : t_limits

	task automatic t_counts();
		@(posedge i_clk_sys) cnt <= 16'hEA60;
		strb(8'h04);
		chk(o_cycle_count, CNT_MAX);
		@(posedge i_clk_sys) cnt <= 16'h0000;
		strb(8'h04);
		chk(o_cycle_count, CNT_MIN);
		@(posedge i_clk_sys) fq <= 32'h0BEB_C200;
		cnt <= 16'h0001;
		strb(8'h01);
		strb(8'h04);
		chk(o_cycle_count, CNT_MAX);
		@(posedge i_clk_sys) fq <= CARRIER_DEF;
		mode_on <= 1'b1;
		strb(8'h01);
		strb(8'h04);
		strb(8'h40);
		chk(o_mode, MODE_BURST);
		@(posedge i_clk_sys) fq <= 32'h0BEB_C200;
		strb(8'h01);
		chk(cf, 1'b1);
		chk(o_carrier_freq, F_MIN);
		chk(o_error_code, ERR_CONFLICT);
		@(posedge i_clk_sys) fq <= CARRIER_DEF;
		cnt <= 16'h0003;
		strb(8'h01);
		@(posedge i_clk_sys) inf <= 1'b1;
		strb(8'h04);
		chk(o_count_infinite, 1'b1);
		@(posedge i_clk_sys) inf <= 1'b0;
		strb(8'h04);
		chk(o_count_infinite, 1'b0);
		chk(o_cycle_count, 16'h0003);
	endtask : t_counts

	// second trigger during the burst must be dropped
	task automatic t_ext_burst();
		i_bfmc_trig_src.set_ext(1'b1);
		wait_act(1'b1, 10);
		chk(o_sync, 1'b0);
		i_bfmc_trig_src.set_ext(1'b0);
		i_bfmc_trig_src.set_ext(1'b1);
		done_n(3);
		wait_act(1'b0, 5);
		chk(o_sync, 1'b1);
		repeat (6) @(posedge i_clk_sys) #1 chk(o_burst_active, 1'b0);
		i_bfmc_trig_src.set_ext(1'b0);
	endtask : t_ext_burst

	task automatic t_line_burst();
		@(posedge i_clk_sys) tsrc <= TS_BACKPLANE;
		lidx <= 3'h2;
		i_bfmc_trig_src.set_line(2, 1'b1);
		wait_act(1'b1, 10);
		done_n(3);
		wait_act(1'b0, 5);
		i_bfmc_trig_src.set_line(2, 1'b0);
	endtask : t_line_burst

	task automatic t_timer_burst();
		@(posedge i_clk_sys) tsrc <= TS_INT;
		wait_act(1'b1, 400);
		done_n(3);
		wait_act(1'b0, 5);
		chk(o_burst_rate, RATE_MAX);
	endtask : t_timer_burst

	task automatic t_gated();
		@(posedge i_clk_sys) gated <= 1'b1;
		tsrc <= TS_EXT;
		i_bfmc_trig_src.set_ext(1'b1);
		repeat (4) @(posedge i_clk_sys);
		#1 chk(o_wave_enable, 1'b1);
		chk(o_burst_active, 1'b0);
		@(posedge i_clk_sys) pos <= 1'b1;
		repeat (2) @(posedge i_clk_sys) #1;
		chk(o_sync, 1'b1);
		@(posedge i_clk_sys) pos <= 1'b0;
		repeat (2) @(posedge i_clk_sys) #1;
		chk(o_sync, 1'b0);
		i_bfmc_trig_src.set_ext(1'b0);
		repeat (4) @(posedge i_clk_sys);
		#1 chk(o_wave_enable, 1'b0);
	endtask : t_gated

	task automatic t_hop();
		int n;
		n = 0;
		@(posedge i_clk_sys) hop_ext <= 1'b1;
		strb(8'h80);
		chk(o_mode, MODE_HOP);
		i_bfmc_trig_src.set_ext(1'b1);
		for (int k = 0; k < 10 && o_hop_select !== 1'b1; k++) @(posedge i_clk_sys) #1;
		chk(o_hop_select, 1'b1);
		while (o_sync === 1'b1 && n < 10) begin
			n++;
			@(posedge i_clk_sys) #1;
		end
		chk(n, SYNC_PULSE_CYC);
		i_bfmc_trig_src.set_ext(1'b0);
		for (int k = 0; k < 10 && o_hop_select !== 1'b0; k++) @(posedge i_clk_sys) #1;
		chk(o_hop_select, 1'b0);
	endtask : t_hop

	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			close_out();
		end
	end

	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		@(posedge i_clk_sys) #1;
		chk(o_cycle_count, CNT_MIN);
		chk(o_burst_rate, BRATE_DEF);
		chk(o_hop_rate, HRATE_DEF);
		chk(o_carrier_freq, CARRIER_DEF);
		chk(o_hop_freq, HOP_DEF);
		chk(o_start_phase, 32'h0000_0000);
		chk(o_mode, MODE_OFF);
		t_limits();
		t_counts();
		t_ext_burst();
		t_line_burst();
		t_timer_burst();
		t_gated();
		t_hop();
		close_out();
	end
endmodule : bfmc_tb_top
`default_nettype wire

// >>> dv/bfmc_trig_src.sv
// model of the external trigger, gate and hop signal source
`timescale 1ns/100ps
`default_nettype none
module bfmc_trig_src (
	// clock
	input  wire logic       i_clk,
	// pins toward the block
	output var  logic       o_ext,
	output var  logic [7:0] o_lines
);
	// front pin idles low, backplane lines idle at their pull-up level
	initial begin
		o_ext = 1'b0;
		o_lines = 8'hFF;
	end
	task automatic set_ext(input logic v);
		@(posedge i_clk) o_ext <= v;
	endtask : set_ext
	// backplane lines are true when pulled low
	task automatic set_line(input int n, input logic act);
		@(posedge i_clk) o_lines[n] <= ~act;
	endtask : set_line
endmodule : bfmc_trig_src
`default_nettype wire

// >>> include/bfmc_pkg.sv
// constants and types for the burst and frequency-shift keying control block
package bfmc_pkg;
	// clock and sync pulse timing
	localparam int CLK_MHZ        = 10;
	localparam int SYNC_PULSE_NS  = 200;
	// pulse must be strictly longer than the minimum, hence one extra cycle
	localparam logic [3:0] SYNC_PULSE_CYC = 4'(SYNC_PULSE_NS * CLK_MHZ / 1000 + 1);
	// frequencies and rates in units of 10 mHz
	localparam logic [31:0] ACC_WRAP     = 32'h3B9A_CA00;
	localparam logic [31:0] F_MIN        = 32'h0000_0001;
	localparam logic [31:0] F_ARB_MIN    = 32'h0000_000A;
	localparam logic [31:0] F_STD_MAX    = 32'h5968_2F00;
	localparam logic [31:0] F_TRI_MAX    = 32'h0098_9680;
	localparam logic [31:0] F_ARB_MAX1   = 32'h1DCD_6500;
	localparam logic [31:0] F_ARB_MAX2   = 32'h0EE6_B280;
	localparam logic [31:0] F_ARB_MAX3   = 32'h0131_2D00;
	localparam logic [31:0] F_ONE_MHZ    = 32'h05F5_E100;
	localparam logic [31:0] CARRIER_DEF  = 32'h0001_86A0;
	localparam logic [31:0] HOP_DEF      = 32'h0000_2710;
	localparam logic [31:0] RATE_MIN     = 32'h0000_0001;
	localparam logic [31:0] RATE_MAX     = 32'h004C_4B40;
	localparam logic [31:0] BRATE_DEF    = 32'h0000_2710;
	localparam logic [31:0] HRATE_DEF    = 32'h0000_03E8;
	localparam logic [13:0] ARB_PTS1     = 14'h2000;
	localparam logic [13:0] ARB_PTS2     = 14'h2FFF;
	// burst count and phase (millidegrees)
	localparam logic [15:0] CNT_MIN      = 16'h0001;
	localparam logic [15:0] CNT_MAX      = 16'hC350;
	localparam logic signed [19:0] PH_MAX = 20'sh5_7E40;
	localparam logic signed [19:0] PH_MIN = -PH_MAX;
	localparam logic signed [15:0] ERR_CONFLICT = 16'shFF23;
	// trigger source codes
	localparam logic [1:0] TS_INT       = 2'h0;
	localparam logic [1:0] TS_EXT       = 2'h1;
	localparam logic [1:0] TS_BACKPLANE = 2'h2;
	// waveform shape codes
	localparam logic [2:0] SH_SINE   = 3'h0;
	localparam logic [2:0] SH_SQUARE = 3'h1;
	localparam logic [2:0] SH_TRI    = 3'h2;
	localparam logic [2:0] SH_RAMP   = 3'h3;
	localparam logic [2:0] SH_ARB    = 3'h4;
	typedef enum logic [1:0] {MODE_OFF, MODE_BURST, MODE_HOP} bfmc_mode_type;
	typedef enum logic {BS_IDLE, BS_RUN} bfmc_bstate_type;
endpackage : bfmc_pkg
